// ===== common/presc_if.sv
// Purpose: Link between counter core and prescaler
// Assumes: Single clock mclk
// Notes:   src_tick and div_tick are one-cycle enables
`timescale 1ns/10ps
interface presc_if;
  logic       src_tick;  // Selected source edge
  logic [1:0] pre;       // Prescaler code
  logic       is_pclk;   // Peripheral clock selected
  logic       clr;       // Hold divider at zero
  logic       div_tick;  // Divided count enable
  modport ctl (output src_tick, pre, is_pclk, clr, input div_tick);
  modport div (input src_tick, pre, is_pclk, clr, output div_tick);
endinterface

// ===== common/wut_consts.svh
// Purpose: Offsets, field positions, reset values and divider counts
// Assumes: Byte offsets on an 8-bit register address
// Notes:   Definitions only
`ifndef WUT_CONSTS_SVH
`define WUT_CONSTS_SVH
// ==========================================================
// Register offsets
`define WUT_OFS_CNT_LO  8'h00
`define WUT_OFS_CNT_HI  8'h04
`define WUT_OFS_CON     8'h08
`define WUT_OFS_INC     8'h0C
`define WUT_OFS_FB_LO   8'h10
`define WUT_OFS_FB_HI   8'h14
`define WUT_OFS_FC_LO   8'h18
`define WUT_OFS_FC_HI   8'h1C
`define WUT_OFS_FD_LO   8'h20
`define WUT_OFS_FD_HI   8'h24
`define WUT_OFS_IEN     8'h28
`define WUT_OFS_STA     8'h2C
`define WUT_OFS_CLR     8'h30
`define WUT_OFS_FA_LO   8'h3C
`define WUT_OFS_FA_HI   8'h40
// ==========================================================
// Reset values
`define WUT_RST_CON     16'h0040
`define WUT_RST_INC     12'h0C8
`define WUT_RST_FA      32'h0000_1900
`define WUT_RST_FB      32'h0000_1FFF
`define WUT_RST_FC      32'h0000_2FFF
`define WUT_RST_FD      32'h0000_3FFF
// ==========================================================
// Control fields and status positions
`define WUT_CON_HOLD    11
`define WUT_CON_CLK_HI  10
`define WUT_CON_CLK_LO  9
`define WUT_CON_WUEN    8
`define WUT_CON_EN      7
`define WUT_CON_FREE    6
`define WUT_CON_FREEZE  3
`define WUT_CON_WMASK   16'h0FCB
`define WUT_CLK_PCLK    2'h0
`define WUT_CLK_LF_A    2'h1
`define WUT_CLK_LF_B    2'h2
`define WUT_INC_SHIFT   5
`define WUT_STA_BUSY    6
`define WUT_FULL_SCALE  32'hFFFF_FFFF
// ==========================================================
// Divider terminal counts (ratio minus one)
`define WUT_TC_DIV1     15'h0000
`define WUT_TC_DIV4     15'h0003
`define WUT_TC_DIV16    15'h000F
`define WUT_TC_DIV256   15'h00FF
`define WUT_TC_DIV32768 15'h7FFF
`endif

// ===== common/wut_pkg.sv
// Purpose: Types shared by the wake-up timer modules
// Assumes: Constants come from the guarded header
// Notes:   State of each module is one packed struct
package wut_pkg;
`include "wut_consts.svh"
  // Interrupt clear sequencer, one-hot
  typedef enum logic [2:0] {
    CLR_IDLE   = 3'b001,
    CLR_FIRST  = 3'b010,
    CLR_SECOND = 3'b100
  } clr_state_type;
  // Whole state of the counter core
  typedef struct packed {
    logic [31:0]   count;
    logic [15:0]   con;
    logic [11:0]   inc;
    logic [11:0]   inc_act;
    logic [31:0]   fa;
    logic [31:0]   fb;
    logic [31:0]   fc;
    logic [31:0]   fd;
    logic [4:0]    ien;
    logic [4:0]    sta;
    logic [4:0]    clr_mask;
    clr_state_type clr_st;
    logic [15:0]   hold_hi;
    logic          frozen;
    logic [15:0]   rd_data;
    logic          irq;
    logic [2:0]    lf_sync;
    logic [2:0]    ec_sync;
  } core_state_type;
  // Whole state of the prescaler
  typedef struct packed {
    logic [14:0] cnt;
    logic        tick;
  } presc_state_type;
endpackage

// ===== hdl/wakeup_timer_32bit.sv
// Purpose: 32-bit wake-up counter with four compare fields
// Assumes: mclk is the peripheral clock at 10 MHz
// Notes:   Slow and external clocks are sampled, not used as clocks
//
// Notes on behaviour
// - 32-bit counter, three selectable clock sources
// - Prescaler divides source, ratios 1 to 32768
// - Peripheral clock with lowest code divides four
// - Counting continues while peripheral clock off
// - Hardware synchronises slow clock, no software care
// - Free-running: zero to all ones, wraps
// - Periodic: zero up to field D, reset
// - Enable starts; clearing enable stops and zeroes
// - Count read as high and low halves
// - Freeze: low read holds high half
// - Four compare fields A to D
// - Interrupt on compare match or full scale
// - Five maskable sources, write-one-to-clear
// - Interval write loads field A bits 16:5
// - Field A advances by interval times 32
// - Field A wraps by subtracting the mode limit
// - Hold bit stops field A updates
// - New interval used after next A match
// - Fields B, C, D written as halves
// - Slow-clock clear takes two cycles, flagged
//
// Decided for this implementation: the register offsets and strobed register access.
`timescale 1ns/10ps
module wakeup_timer_32bit
  import wut_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // Register port
  input  wire logic [7:0]  addr,
  input  wire logic [15:0] wr_data,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output logic      [15:0] rd_data,
  // Clock sources and power state
  input  wire logic        pclk_on,
  input  wire logic        low_freq_oscillator,
  input  wire logic        external_clock_input,
  // Interrupt / wake-up request and clear-in-flight status
  output logic             wakeup_irq,
  output logic             clear_in_flight_flag
);
  core_state_type q;       // Registered state
  core_state_type n;       // Next state
  presc_if        pif ();  // Prescaler link

  // ========================================================
  // Derived control
  logic [1:0] clk_sel;     // Source select field
  logic       running;     // Enable bit
  logic       free_run;    // Free-running mode
  logic       hold_a;      // Field A update hold
  logic       lf_edge;     // Rising edge, slow oscillator
  logic       ec_edge;     // Rising edge, external clock
  logic       lf_sel;      // Slow oscillator selected
  logic       src_ok;      // Source may advance

  assign clk_sel  = q.con[`WUT_CON_CLK_HI:`WUT_CON_CLK_LO];
  assign running  = q.con[`WUT_CON_EN];
  assign free_run = q.con[`WUT_CON_FREE];
  assign hold_a   = q.con[`WUT_CON_HOLD];
  assign lf_sel   = (clk_sel == `WUT_CLK_LF_A) || (clk_sel == `WUT_CLK_LF_B);

  // Edges come from the second and third sync stages only
  assign lf_edge = q.lf_sync[1] & ~q.lf_sync[2];
  assign ec_edge = q.ec_sync[1] & ~q.ec_sync[2];

  // Slow sources keep counting while the peripheral clock is off,
  // provided wake-up operation is enabled
  assign src_ok = pclk_on | q.con[`WUT_CON_WUEN];

  // ========================================================
  // Source select and prescaler hookup
  always_comb begin
    // Peripheral clock ticks every cycle while it is on
    case (clk_sel)
      `WUT_CLK_PCLK: pif.src_tick = pclk_on;
      `WUT_CLK_LF_A: pif.src_tick = lf_edge & src_ok;
      `WUT_CLK_LF_B: pif.src_tick = lf_edge & src_ok;
      default:       pif.src_tick = ec_edge & src_ok;
    endcase
  end

  assign pif.pre     = q.con[1:0];
  assign pif.is_pclk = (clk_sel == `WUT_CLK_PCLK);
  assign pif.clr     = ~running;

  wut_prescaler u_presc (
    .mclk (mclk),
    .rst  (rst),
    .pif  (pif)
  );

  // ========================================================
  // Field A advance with wrap against the mode limit
  function automatic logic [31:0] advance_a(input logic [31:0] base,
                                            input logic [11:0] step,
                                            input logic [31:0] lim);
    logic [32:0] sum;
    logic [32:0] dif;
    sum = {1'b0, base} + {16'h0000, step, 5'h00};
    dif = sum - {1'b0, lim};
    // Past the limit: old + step*32 - limit
    if (sum > {1'b0, lim}) begin
      advance_a = dif[31:0];
    end else begin
      advance_a = sum[31:0];
    end
  endfunction

  // ========================================================
  // Next state
  always_comb begin
    logic [31:0] cnt_n;    // Count after this tick
    logic [31:0] lim;      // Mode limit
    logic [4:0]  ev;       // Events this cycle
    logic [4:0]  clr_now;  // Flags cleared this cycle
    cnt_n   = 32'h0000_0000;
    lim     = free_run ? `WUT_FULL_SCALE : q.fd;
    ev      = 5'h00;
    clr_now = 5'h00;
    n       = q;

    // Pin sampling: two stages, then one for edge detection
    n.lf_sync = {q.lf_sync[1:0], low_freq_oscillator};
    n.ec_sync = {q.ec_sync[1:0], external_clock_input};

    // Counter
    if (!running) begin
      // Disabled: counter stopped and cleared
      n.count = 32'h0000_0000;
    end else if (pif.div_tick) begin
      if (free_run) begin
        // Wraps to zero after all ones
        cnt_n = q.count + 32'h0000_0001;
      end else if (q.count == q.fd) begin
        // Periodic: back to zero after reaching D
        cnt_n = 32'h0000_0000;
      end else begin
        cnt_n = q.count + 32'h0000_0001;
      end
      n.count = cnt_n;
      // Compare events on the new count
      ev[0] = (cnt_n == q.fa);
      ev[1] = (cnt_n == q.fb);
      ev[2] = (cnt_n == q.fc);
      ev[3] = (cnt_n == q.fd);
      ev[4] = free_run && (cnt_n == `WUT_FULL_SCALE);
      // Field A steps on its own match unless held
      if (ev[0] && !hold_a) begin
        n.fa      = advance_a(q.fa, q.inc_act, lim);
        // Pending interval becomes active after this match
        n.inc_act = q.inc;
      end
    end

    // Interrupt clear sequencing
    case (q.clr_st)
      CLR_IDLE: begin
        n.clr_st = CLR_IDLE;
      end
      CLR_FIRST: begin
        if (lf_edge) begin
          n.clr_st = CLR_SECOND;
        end
      end
      CLR_SECOND: begin
        // Second slow edge: the clear takes effect
        if (lf_edge) begin
          clr_now    = q.clr_mask;
          n.clr_mask = 5'h00;
          n.clr_st   = CLR_IDLE;
        end
      end
      default: begin
        n.clr_st   = CLR_IDLE;
        n.clr_mask = 5'h00;
      end
    endcase

    // Register reads, answered in the next cycle
    n.rd_data = 16'h0000;
    if (rd_en) begin
      case (addr)
        `WUT_OFS_CNT_LO: begin
          n.rd_data = q.count[15:0];
          // Freeze the high half for an atomic pair
          if (q.con[`WUT_CON_FREEZE]) begin
            n.hold_hi = q.count[31:16];
            n.frozen  = 1'b1;
          end
        end
        `WUT_OFS_CNT_HI: begin
          n.rd_data = q.frozen ? q.hold_hi : q.count[31:16];
          n.frozen  = 1'b0;
        end
        `WUT_OFS_CON:   n.rd_data = q.con;
        `WUT_OFS_INC:   n.rd_data = {4'h0, q.inc};
        `WUT_OFS_FB_LO: n.rd_data = q.fb[15:0];
        `WUT_OFS_FB_HI: n.rd_data = q.fb[31:16];
        `WUT_OFS_FC_LO: n.rd_data = q.fc[15:0];
        `WUT_OFS_FC_HI: n.rd_data = q.fc[31:16];
        `WUT_OFS_FD_LO: n.rd_data = q.fd[15:0];
        `WUT_OFS_FD_HI: n.rd_data = q.fd[31:16];
        `WUT_OFS_IEN:   n.rd_data = {11'h000, q.ien};
        `WUT_OFS_STA: begin
          n.rd_data = {9'h000, (q.clr_st != CLR_IDLE), 1'b0, q.sta};
        end
        `WUT_OFS_FA_LO: n.rd_data = q.fa[15:0];
        `WUT_OFS_FA_HI: n.rd_data = q.fa[31:16];
        // Clear register and holes read as zero
        default:        n.rd_data = 16'h0000;
      endcase
    end

    // Register writes; software wins over the hardware step
    if (wr_en) begin
      case (addr)
        `WUT_OFS_CON: begin
          n.con = wr_data & `WUT_CON_WMASK;
        end
        `WUT_OFS_INC: begin
          n.inc = wr_data[11:0];
          // Loads field A unless software holds it
          if (!hold_a) begin
            n.fa = {15'h0000, wr_data[11:0], 5'h00};
          end
          // While stopped the interval is used at once
          if (!running) begin
            n.inc_act = wr_data[11:0];
          end
        end
        // Software-owned fields, as two halves each
        `WUT_OFS_FB_LO: n.fb[15:0]  = wr_data;
        `WUT_OFS_FB_HI: n.fb[31:16] = wr_data;
        `WUT_OFS_FC_LO: n.fc[15:0]  = wr_data;
        `WUT_OFS_FC_HI: n.fc[31:16] = wr_data;
        // No guard on D; software keeps to when it may write it
        `WUT_OFS_FD_LO: n.fd[15:0]  = wr_data;
        `WUT_OFS_FD_HI: n.fd[31:16] = wr_data;
        `WUT_OFS_IEN: begin
          // Masking is how software guards B/C rewrites
          n.ien = wr_data[4:0];
        end
        `WUT_OFS_CLR: begin
          if (lf_sel) begin
            // Slow clock: clear needs two oscillator cycles
            n.clr_mask = n.clr_mask | wr_data[4:0];
            // A clear landing as the last one completes starts afresh
            if (n.clr_st == CLR_IDLE) begin
              n.clr_st = CLR_FIRST;
            end
          end else begin
            clr_now = clr_now | wr_data[4:0];
          end
        end
        default: begin
          // Read-only or unmapped: ignored
        end
      endcase
    end

    // Sticky flags: a new event wins over a clear
    n.sta = (q.sta & ~clr_now) | ev;

    // Request line: any enabled pending flag
    n.irq = |(n.sta & n.ien);
  end

  // ========================================================
  // State register
  always_ff @(posedge mclk) begin
    if (rst) begin
      q          <= '0;
      q.con      <= `WUT_RST_CON;
      q.inc      <= `WUT_RST_INC;
      q.inc_act  <= `WUT_RST_INC;
      q.fa       <= `WUT_RST_FA;
      q.fb       <= `WUT_RST_FB;
      q.fc       <= `WUT_RST_FC;
      q.fd       <= `WUT_RST_FD;
      q.clr_st   <= CLR_IDLE;
    end else begin
      q <= n;
    end
  end

  // ========================================================
  // Outputs: read data and request straight from flip-flops, clear flag decoded from clr_st
  assign rd_data              = q.rd_data;
  assign wakeup_irq           = q.irq;
  assign clear_in_flight_flag = (q.clr_st != CLR_IDLE);
endmodule

// ===== hdl/wut_prescaler.sv
// Purpose: Divides the selected source tick into a count enable
// Assumes: Source tick is a one-cycle pulse on mclk
// Notes:   Output tick comes from a flip-flop
`timescale 1ns/10ps
module wut_prescaler
  import wut_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Core link
  presc_if.div     pif
);
  presc_state_type q;  // Registered state
  presc_state_type n;  // Next state

  // ========================================================
  // Terminal count for a code
  function automatic logic [14:0] term_count(input logic [1:0] code,
                                             input logic       pclk);
    case (code)
      2'h0:    term_count = pclk ? `WUT_TC_DIV4 : `WUT_TC_DIV1;
      2'h1:    term_count = `WUT_TC_DIV16;
      2'h2:    term_count = `WUT_TC_DIV256;
      default: term_count = `WUT_TC_DIV32768;
    endcase
  endfunction

  // ========================================================
  // Next state: count source ticks, pulse at terminal count
  always_comb begin
    n = q;
    n.tick = 1'b0;
    if (pif.clr) begin
      // Timer off: restart from zero so the first period is whole
      n.cnt = 15'h0000;
    end else if (pif.src_tick) begin
      if (q.cnt >= term_count(pif.pre, pif.is_pclk)) begin
        n.cnt  = 15'h0000;
        n.tick = 1'b1;
      end else begin
        n.cnt = q.cnt + 15'h0001;
      end
    end
  end

  // State register
  always_ff @(posedge mclk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign pif.div_tick = q.tick;
endmodule

// ===== verif/wakeup_timer_32bit_assertions.sv
// Purpose: Port-level checks of the wake-up timer
// Assumes: Sees only the top-level ports, one clock
// Notes:   Control word is shadowed from bus writes
`timescale 1ns/10ps
`include "wut_consts.svh"
module wut_checker (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        rst,
  // Register port
  input wire logic [7:0]  addr,
  input wire logic [15:0] wr_data,
  input wire logic        wr_en,
  input wire logic        rd_en,
  input wire logic [15:0] rd_data,
  // Event outputs
  input wire logic        wakeup_irq,
  input wire logic        clear_in_flight_flag
);
  // ==========================================================
  // Helper logic
  logic [15:0] con_r;     // Shadow of the control word
  logic        slow_sel;  // Slow oscillator picked

  // Shadow follows masked writes, so dropped bits never count
  always_ff @(posedge mclk) begin
    if (rst) begin
      con_r <= `WUT_RST_CON;
    end else if (wr_en && addr == `WUT_OFS_CON) begin
      con_r <= wr_data & `WUT_CON_WMASK;
    end
  end
  assign slow_sel = (con_r[10:9] == 2'h1) || (con_r[10:9] == 2'h2);

  // ==========================================================
  // Assertions
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  chk_rd_idle: assert property (
    !$past(rd_en) |-> rd_data == 16'h0000)
    else $error("read data not zero outside read cycle");
  chk_clr_reads: assert property (
    $past(rd_en) && $past(addr) == `WUT_OFS_CLR |-> rd_data == 16'h0000)
    else $error("clear register did not read zero");
  chk_con_mask: assert property (
    $past(rd_en) && $past(addr) == `WUT_OFS_CON |-> (rd_data & ~`WUT_CON_WMASK) == 16'h0000)
    else $error("reserved control bits read non-zero");
  chk_sta_flag: assert property (
    $past(rd_en) && $past(addr) == `WUT_OFS_STA |-> rd_data[6] == $past(clear_in_flight_flag))
    else $error("status bit 6 differs from clear flag");
  chk_irq_quiet: assert property (
    $past(rd_en) && $past(addr) == `WUT_OFS_STA && rd_data[4:0] == 5'h00 |-> !$past(wakeup_irq))
    else $error("interrupt high with no status bit");
  chk_slow_clear: assert property (
    wr_en && addr == `WUT_OFS_CLR && slow_sel |=> clear_in_flight_flag)
    else $error("slow clear did not raise the flag");
  chk_clear_ends: assert property (
    $rose(clear_in_flight_flag) |-> ##[1:200] !clear_in_flight_flag)
    else $error("clear flag stuck high");
  chk_cnt_idle: assert property (
    $past(rd_en) && $past(addr) == `WUT_OFS_CNT_LO && !$past(con_r[7])
      && !$past(con_r[7], 2) |-> rd_data == 16'h0000)
    else $error("count not zero while disabled");
endmodule

// ===== verif/wakeup_timer_32bit_tb.sv
// Purpose: Self-checking bench for the wake-up timer
// Assumes: Slow oscillator toggles every 10 mclk cycles
// Notes:   Expected values reckoned from the rules only
`timescale 1ns/10ps
`include "wut_consts.svh"
module wakeup_timer_32bit_tb import wut_pkg::*;;
  // ==========================================================
  // Signals
  logic        mclk, rst, wr_en, rd_en, pclk_on, lf_osc, ext_clk;
  logic [7:0]  addr;
  logic [15:0] wr_data, rd_data, got, v1;
  logic        wakeup_irq, clear_in_flight_flag;
  int          error_cnt, checks, cyc, seed, i, w;
  int          exp_q[$];  // Reset value model, one per offset

  wakeup_timer_32bit dut_u (
    .mclk(mclk), .rst(rst), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .pclk_on(pclk_on),
    .low_freq_oscillator(lf_osc), .external_clock_input(ext_clk),
    .wakeup_irq(wakeup_irq), .clear_in_flight_flag(clear_in_flight_flag));

  // ==========================================================
  // Clocks and timeout; slow clock locked to mclk so counts are exact
  initial mclk = 1'b0;
  always #50 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc % 10 == 9) lf_osc <= ~lf_osc;
    ext_clk <= cyc[2];
    if (cyc == 20000) begin
      error_cnt++;
      close_out();
    end
  end

  // ==========================================================
  // Bus tasks; each starts and ends in a rising-edge time step
  task automatic check(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    wr_en   <= 1'b1;
    addr    <= a;
    wr_data <= d;
    @(posedge mclk);
    wr_en <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] q);
    rd_en <= 1'b1;
    addr  <= a;
    @(posedge mclk);
    rd_en <= 1'b0;
    #1 q = rd_data;
    @(posedge mclk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [15:0] e);
    rd(a, got);
    check(got, e);
  endtask
  task automatic gap(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic close_out();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    seed = 89;
    error_cnt = 0;
    checks = 0;
    cyc = 0;
    {rst, wr_en, rd_en, addr, wr_data, pclk_on, lf_osc, ext_clk} = '0;
    rst = 1'b1;
    pclk_on = 1'b1;
    gap(3);
    rst <= 1'b0;
    @(posedge mclk);
    // Reset values of offsets 0x00..0x40, unmapped ones read zero
    exp_q = '{0, 0, 'h40, 'hC8, 'h1FFF, 0, 'h2FFF, 0, 'h3FFF, 0, 0, 0, 0, 0, 0, 'h1900, 0};
    for (i = 0; i < 17; i++) rdc(8'(i * 4), 16'(exp_q[i]));
    wr(`WUT_OFS_CON, 16'hFFFF);
    rdc(`WUT_OFS_CON, `WUT_CON_WMASK);
    wr(`WUT_OFS_CON, 16'h0000);
    // Random halves of fields B and C, written while their enables are off
    for (i = 0; i < 4; i++) begin
      v1 = 16'($random(seed));
      wr(8'h10 + 8'(i * 4), v1);
      rdc(8'h10 + 8'(i * 4), v1);
    end
    // Peripheral clock: codes 00/01/10 give 4, 16, 256 over 512 cycles
    for (i = 0; i < 3; i++) begin
      wr(`WUT_OFS_CON, 16'h00C0 | 16'(i));
      rd(`WUT_OFS_CNT_LO, v1);
      gap(510);
      rd(`WUT_OFS_CNT_LO, got);
      check(got - v1, (i == 0) ? 16'h0080 : (i == 1) ? 16'h0020 : 16'h0002);
    end
    wr(`WUT_OFS_CON, 16'h0000);
    rdc(`WUT_OFS_CNT_LO, 16'h0000);
    // Slow clock keeps counting with the peripheral clock off
    wr(`WUT_OFS_CON, 16'h03C0);
    pclk_on <= 1'b0;
    rd(`WUT_OFS_CNT_LO, v1);
    gap(398);
    rd(`WUT_OFS_CNT_LO, got);
    check(got - v1, 16'h0014);
    // External clock pin: one count per pin period of 8 cycles
    wr(`WUT_OFS_CON, 16'h07C0);
    rd(`WUT_OFS_CNT_LO, v1);
    gap(398);
    rd(`WUT_OFS_CNT_LO, got);
    check(got - v1, 16'h0032);
    // Periodic to field D, interrupt on the D match
    wr(`WUT_OFS_CON, 16'h0200);
    wr(`WUT_OFS_FD_LO, 16'h0004);
    wr(`WUT_OFS_IEN, 16'h0008);
    wr(`WUT_OFS_CON, 16'h0380);
    for (i = 0; i < 6; i++) begin
      gap(5 + ($unsigned($random(seed)) % 40));
      rd(`WUT_OFS_CNT_LO, got);
      check({15'h0, got > 16'h0004}, 16'h0000);
    end
    gap(100);
    rdc(`WUT_OFS_STA, 16'h0008);
    check({15'h0, wakeup_irq}, 16'h0001);
    wr(`WUT_OFS_IEN, 16'h0000);
    gap(1);
    check({15'h0, wakeup_irq}, 16'h0000);
    wr(`WUT_OFS_IEN, 16'h0008);
    pclk_on <= 1'b1;
    wr(`WUT_OFS_CON, 16'h0200);
    gap(4);
    // Slow clear takes two oscillator cycles
    wr(`WUT_OFS_CLR, 16'h0008);
    #1 check({15'h0, clear_in_flight_flag}, 16'h0001);
    w = 0;
    while (clear_in_flight_flag !== 1'b0 && w < 200) begin
      @(posedge mclk);
      #1 w++;
    end
    check({15'h0, w >= 15 && w <= 50}, 16'h0001);
    @(posedge mclk);
    rdc(`WUT_OFS_STA, 16'h0000);
    check({15'h0, wakeup_irq}, 16'h0000);
    // Field A: load, step with wrap at D, hold
    wr(`WUT_OFS_CON, 16'h0000);
    wr(`WUT_OFS_FD_LO, 16'h0070);
    wr(`WUT_OFS_INC, 16'h0003);
    rdc(`WUT_OFS_FA_LO, 16'h0060);
    rdc(`WUT_OFS_FA_HI, 16'h0000);
    wr(`WUT_OFS_CON, 16'h0080);
    gap(420);
    rdc(`WUT_OFS_FA_LO, 16'h0050);
    rdc(`WUT_OFS_STA, 16'h0001);
    wr(`WUT_OFS_CON, 16'h0880);
    wr(`WUT_OFS_INC, 16'h0005);
    rdc(`WUT_OFS_FA_LO, 16'h0050);
    wr(`WUT_OFS_CON, 16'h0000);
    wr(`WUT_OFS_CLR, 16'h001F);
    rdc(`WUT_OFS_STA, 16'h0000);
    close_out();
  end
endmodule

bind wakeup_timer_32bit wut_checker chk_u (
  .mclk(mclk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
  .rd_en(rd_en), .rd_data(rd_data), .wakeup_irq(wakeup_irq),
  .clear_in_flight_flag(clear_in_flight_flag));
